// *** logic/scnt_top.sv ***
// Synchronous 4-bit counter with an AHB-Lite register port.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`default_nettype none
`include "scnt_defines.svh"

module scnt_top
    import scnt_pkg::*;
#(
    parameter scnt_modulus_t MODULUS = SCNT_MOD_DECADE,
    parameter scnt_clear_t CLEAR_KIND = SCNT_CLR_SYNC
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,

    // AHB-Lite slave inputs.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,

    // AHB-Lite slave outputs.
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,

    // Counter inputs.
    input wire logic async_clear_n,
    input wire logic count_enable_chain,

    // Counter outputs.
    output logic [3:0] count_outputs,
    output logic carry_out
);

    // ======================================================================
    // Clock enable
    // ======================================================================

    // The enable is registered and shown as hreadyout, so the bus stalls
    // in exactly the cycles in which all other state is frozen, save a master clear of the count.
    logic ready_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b1;
        end else begin
            ready_q <= ce;
        end
    end

    logic en;

    assign en = ready_q;

    // ======================================================================
    // Address decode
    // ======================================================================

    // Shared by the read path and the write path.
    function automatic logic addr_hit(input logic [31:0] addr,
                                      input logic [31:0] target);
        return addr == target;
    endfunction

    // An address phase is taken when the bus is ready and the slave chosen.
    logic take;

    assign take = en & hsel & hready & htrans[1];

    // ======================================================================
    // Data-phase bookkeeping
    // ======================================================================

    // Only whole-word writes are honoured; narrower ones complete unused.
    logic wr_pend_q;
    logic [31:0] wr_addr_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end else if (en) begin
            wr_pend_q <= take & hwrite & (hsize == `SCNT_HSIZE_WORD);
            wr_addr_q <= haddr;
        end
    end

    logic wr_ctrl;
    logic wr_stat;

    assign wr_ctrl = en & wr_pend_q & addr_hit(wr_addr_q, `SCNT_CTRL_ADDR);
    assign wr_stat = en & wr_pend_q & addr_hit(wr_addr_q, `SCNT_STAT_ADDR);

    // ======================================================================
    // Control register
    // ======================================================================

    // Reset word, split into its fields below.
    localparam logic [31:0] CTRL_RST = `SCNT_CTRL_RESET;

    // Mode inputs, held as levels until software changes them.
    logic load_n_q;
    logic par_q;
    logic sclr_n_q;
    logic [3:0] preset_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_n_q <= CTRL_RST[`SCNT_CTRL_LOAD_N_BIT];
            par_q <= CTRL_RST[`SCNT_CTRL_PAR_BIT];
            sclr_n_q <= CTRL_RST[`SCNT_CTRL_SCLR_N_BIT];
            preset_q <= CTRL_RST[`SCNT_CTRL_PRESET_MSB:
                                 `SCNT_CTRL_PRESET_LSB];
        end else if (wr_ctrl) begin
            load_n_q <= hwdata[`SCNT_CTRL_LOAD_N_BIT];
            par_q <= hwdata[`SCNT_CTRL_PAR_BIT];
            sclr_n_q <= hwdata[`SCNT_CTRL_SCLR_N_BIT];
            preset_q <= hwdata[`SCNT_CTRL_PRESET_MSB:`SCNT_CTRL_PRESET_LSB];
        end
    end

    // ======================================================================
    // One-shot preset
    // ======================================================================

    // Arming loads the preset at the next enabled edge only, which saves
    // software a second write to raise the load enable again.
    logic load_once_q;
    logic arm_once;

    assign arm_once = wr_ctrl & hwdata[`SCNT_CTRL_LOAD_ONCE_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            load_once_q <= 1'b0;
        end else if (arm_once) begin
            load_once_q <= 1'b1;
        end else if (en) begin
            load_once_q <= 1'b0;
        end
    end

    // ======================================================================
    // Counter
    // ======================================================================

    scnt_ctrl_if cif ();

    // The chain enable comes from a neighbouring stage on this same clock,
    // so it is used directly; a synchroniser would break the look-ahead.
    assign cif.load_n = load_n_q & ~load_once_q;
    assign cif.cnt_par = par_q;
    assign cif.cnt_chain = count_enable_chain;
    assign cif.sclr_n = sclr_n_q;
    assign cif.preset = preset_q;

    scnt_counter_core #(
        .CLEAR_KIND(CLEAR_KIND)
    ) u_core (
        .clk(clk),
        .reset(reset),
        .async_clear_n(async_clear_n),
        .en(en),
        .cif(cif)
    );

    scnt_next_decode #(
        .MODULUS(MODULUS)
    ) u_decode (
        .cif(cif)
    );

    // ======================================================================
    // Counter pins
    // ======================================================================

    // The carry is a gate after the state register, not a flip-flop: the
    // chain enable must pull it low without waiting for an edge.
    assign count_outputs = cif.count;

    assign carry_out = cif.term & count_enable_chain;

    // ======================================================================
    // Wrap flag
    // ======================================================================

    // Sticky record that the counter passed its terminal state; writing a
    // one clears it, and a wrap in that same cycle keeps it set.
    logic wrap_q;
    logic wrap_evt;
    logic clear_ok;

    assign clear_ok = (CLEAR_KIND == SCNT_CLR_ASYNC) | sclr_n_q;

    assign wrap_evt = en & clear_ok & cif.load_n & par_q
        & count_enable_chain & cif.term;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrap_q <= 1'b0;
        end else if (wrap_evt) begin
            wrap_q <= 1'b1;
        end else if (wr_stat && hwdata[`SCNT_STAT_WRAP_BIT]) begin
            wrap_q <= 1'b0;
        end
    end

    // ======================================================================
    // Read path
    // ======================================================================

    // Control word as software sees it; a write finishing in this cycle is
    // forwarded so that a read straight after it returns the new value.
    logic [31:0] ctrl_word;

    logic [31:0] stat_word;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`SCNT_CTRL_LOAD_N_BIT] = load_n_q;
        ctrl_word[`SCNT_CTRL_PAR_BIT] = par_q;
        ctrl_word[`SCNT_CTRL_SCLR_N_BIT] = sclr_n_q;
        ctrl_word[`SCNT_CTRL_LOAD_ONCE_BIT] = load_once_q;
        ctrl_word[`SCNT_CTRL_PRESET_MSB:`SCNT_CTRL_PRESET_LSB] = preset_q;
        // All fields sit in the low byte, so one slice forwards them.
        if (wr_ctrl) begin
            ctrl_word[`SCNT_CTRL_PRESET_MSB:0] =
                hwdata[`SCNT_CTRL_PRESET_MSB:0];
        end
    end

    // Status word: live state of the counter and its pins.
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`SCNT_STAT_COUNT_MSB:`SCNT_STAT_COUNT_LSB] = cif.count;
        stat_word[`SCNT_STAT_CARRY_BIT] = cif.term & count_enable_chain;
        stat_word[`SCNT_STAT_CHAIN_BIT] = count_enable_chain;
        stat_word[`SCNT_STAT_DECADE_BIT] = (MODULUS == SCNT_MOD_DECADE);
        stat_word[`SCNT_STAT_ASYNC_BIT] = (CLEAR_KIND == SCNT_CLR_ASYNC);
        stat_word[`SCNT_STAT_WRAP_BIT] = wrap_q;
    end

    // Read data is captured at the address phase and stands through the
    // data phase; unmapped addresses read as zero.
    logic [31:0] rdata_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (en) begin
            if (take && !hwrite && addr_hit(haddr, `SCNT_CTRL_ADDR)) begin
                rdata_q <= ctrl_word;
            end else if (take && !hwrite
                         && addr_hit(haddr, `SCNT_STAT_ADDR)) begin
                rdata_q <= stat_word;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // The response never signals an error, so it is a constant flip-flop.
    logic resp_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resp_q <= `SCNT_HRESP_OKAY;
        end else begin
            resp_q <= `SCNT_HRESP_OKAY;
        end
    end

    // ======================================================================
    // Bus outputs
    // ======================================================================

    assign hreadyout = ready_q;
    assign hrdata = rdata_q;
    assign hresp = resp_q;

endmodule // scnt_top

`default_nettype wire

// *** common/scnt_defines.svh ***
// Offsets, fields, reset values and counts of the counter.
`ifndef SCNT_DEFINES_SVH
`define SCNT_DEFINES_SVH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define SCNT_CTRL_ADDR 32'h0000_0000
`define SCNT_STAT_ADDR 32'h0000_0004

// ==========================================================================
// Control register fields
// ==========================================================================
`define SCNT_CTRL_LOAD_N_BIT 0
`define SCNT_CTRL_PAR_BIT 1
`define SCNT_CTRL_SCLR_N_BIT 2
`define SCNT_CTRL_LOAD_ONCE_BIT 3
`define SCNT_CTRL_PRESET_LSB 4
`define SCNT_CTRL_PRESET_MSB 7
`define SCNT_CTRL_RESET 32'h0000_0005

// ==========================================================================
// Status register fields
// ==========================================================================
`define SCNT_STAT_COUNT_LSB 0
`define SCNT_STAT_COUNT_MSB 3
`define SCNT_STAT_CARRY_BIT 4
`define SCNT_STAT_CHAIN_BIT 5
`define SCNT_STAT_DECADE_BIT 6
`define SCNT_STAT_ASYNC_BIT 7
`define SCNT_STAT_WRAP_BIT 8

// ==========================================================================
// Count values
// ==========================================================================
`define SCNT_ZERO 4'h0
`define SCNT_ONE 4'h1
`define SCNT_DEC_TERM 4'h9
`define SCNT_BIN_TERM 4'hF

// ==========================================================================
// Bus encodings
// ==========================================================================
`define SCNT_HSIZE_WORD 3'h2
`define SCNT_HRESP_OKAY 1'h0

`endif

// *** common/scnt_pkg.sv ***
// Types and shared count arithmetic of the counter.
`default_nettype none
`include "scnt_defines.svh"

package scnt_pkg;

    // ======================================================================
    // Build-time variants
    // ======================================================================
    typedef enum logic {SCNT_MOD_DECADE, SCNT_MOD_BINARY} scnt_modulus_t;
    typedef enum logic {SCNT_CLR_SYNC, SCNT_CLR_ASYNC} scnt_clear_t;

    // ======================================================================
    // Count arithmetic
    // ======================================================================
    // True in the last state of the sequence for the chosen modulus.
    function automatic logic scnt_is_terminal(input logic [3:0] value,
                                              input scnt_modulus_t modulus);
        if (modulus == SCNT_MOD_DECADE) begin
            return value == `SCNT_DEC_TERM;
        end
        return value == `SCNT_BIN_TERM;
    endfunction

    // Next state of an enabled count; illegal decade states go to zero.
    function automatic logic [3:0] scnt_advance(input logic [3:0] value,
                                               input scnt_modulus_t modulus);
        if (scnt_is_terminal(value, modulus)
            || (modulus == SCNT_MOD_DECADE && value > `SCNT_DEC_TERM)) begin
            return `SCNT_ZERO;
        end
        return value + `SCNT_ONE;
    endfunction

endpackage

`default_nettype wire

// *** common/scnt_ctrl_if.sv ***
// Signals between the register side, the count register and its decoder.
`default_nettype none

interface scnt_ctrl_if;
    logic load_n;
    logic cnt_par;
    logic cnt_chain;
    logic sclr_n;
    logic [3:0] preset;
    logic [3:0] count;
    logic [3:0] next_count;
    logic term;

    // Register side drives the mode inputs and watches the state.
    modport regs (output load_n, cnt_par, cnt_chain, sclr_n, preset,
                  input count, term);
    // Count register.
    modport core (input load_n, cnt_par, cnt_chain, sclr_n, preset,
                  next_count, output count);
    // Next-state and terminal decoder.
    modport decode (input count, output next_count, term);
endinterface

`default_nettype wire

// *** logic/scnt_next_decode.sv ***
// Next-state and terminal-state decoder of the counter.
`default_nettype none

module scnt_next_decode
    import scnt_pkg::*;
#(
    parameter scnt_modulus_t MODULUS = SCNT_MOD_DECADE
) (
    // Link to the count register.
    scnt_ctrl_if.decode cif
);

    // ======================================================================
    // Decode
    // ======================================================================
    // Pure logic on the present state, so the carry look-ahead of a cascade
    // sees the terminal state as soon as the register settles.
    assign cif.next_count = scnt_advance(cif.count, MODULUS);
    assign cif.term = scnt_is_terminal(cif.count, MODULUS);

endmodule // scnt_next_decode

`default_nettype wire

// *** logic/scnt_counter_core.sv ***
// Four-bit count register with preset, hold and both reset variants.
`default_nettype none

module scnt_counter_core
    import scnt_pkg::*;
#(
    parameter scnt_clear_t CLEAR_KIND = SCNT_CLR_SYNC
) (
    // Clock, resets and enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic async_clear_n,
    input wire logic en,
    // Link to the register side and decoder.
    scnt_ctrl_if.core cif
);

    // ======================================================================
    // Asynchronous clear
    // ======================================================================
    // The master clear acts at once, so it joins the system reset here
    // rather than passing a synchroniser; it must be glitch free.
    logic arst;
    logic sync_clear;
    assign arst = reset
        | ((CLEAR_KIND == SCNT_CLR_ASYNC) & ~async_clear_n);
    assign sync_clear = (CLEAR_KIND == SCNT_CLR_SYNC) & ~cif.sclr_n;

    // ======================================================================
    // Count register
    // ======================================================================
    // Clear beats preset, preset beats count, otherwise the state holds.
    logic [3:0] count_q;
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            count_q <= `SCNT_ZERO;
        end else if (en) begin
            if (sync_clear) begin
                count_q <= `SCNT_ZERO;
            end else if (!cif.load_n) begin
                count_q <= cif.preset;
            end else if (cif.cnt_par && cif.cnt_chain) begin
                count_q <= cif.next_count;
            end else begin
                count_q <= count_q;
            end
        end
    end

    assign cif.count = count_q;

endmodule // scnt_counter_core

`default_nettype wire

// *** testbench/scnt_top_asserts.sv ***
// Checker of the counter's ports, bound to its top module.
`default_nettype none
`include "scnt_defines.svh"

module scnt_top_asserts
    import scnt_pkg::*;
#(
    parameter scnt_modulus_t MODULUS = SCNT_MOD_DECADE,
    parameter scnt_clear_t CLEAR_KIND = SCNT_CLR_SYNC
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Counter pins.
    input wire logic async_clear_n,
    input wire logic count_enable_chain,
    input wire logic [3:0] count_outputs,
    input wire logic carry_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Control shadow
    // ======================================================================
    logic taken;
    logic clr_on;
    logic mode_ok;
    logic wr_pend_q;
    logic [31:0] ctrl_q;
    logic [3:0] term;
    logic [3:0] nxt;
    logic [3:0] preset;

    // Mode checks stand aside while the last control write holds a load-once arm.
    assign taken = hsel && hready && htrans[1] && hreadyout;
    assign clr_on = CLEAR_KIND == SCNT_CLR_ASYNC && !async_clear_n;
    assign mode_ok = hreadyout && !clr_on && !ctrl_q[3]
        && (CLEAR_KIND == SCNT_CLR_ASYNC || ctrl_q[2]);
    assign term = MODULUS == SCNT_MOD_DECADE ? `SCNT_DEC_TERM : `SCNT_BIN_TERM;
    assign nxt = count_outputs >= term ? `SCNT_ZERO : count_outputs + 4'h1;
    assign preset = ctrl_q[7:4];

    // Remember a word write to the control register until its data phase.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'h0;
        end else if (hreadyout) begin
            wr_pend_q <= taken && hwrite && haddr == `SCNT_CTRL_ADDR
                && hsize == `SCNT_HSIZE_WORD;
        end
    end

    // The shadow takes the write data at the end of the data phase.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `SCNT_CTRL_RESET;
        end else if (hreadyout && wr_pend_q) begin
            ctrl_q <= hwdata;
        end
    end

    // ======================================================================
    // Properties
    // ======================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_lag;
        hreadyout ##1 !hreadyout;
    endsequence
    property p_carry_decode;
        carry_out == (count_enable_chain && count_outputs == term);
    endproperty
    property p_async_clear;
        clr_on |-> count_outputs == `SCNT_ZERO && !carry_out;
    endproperty
    property p_load;
        mode_ok && !ctrl_q[0] |=> clr_on || count_outputs == $past(preset);
    endproperty
    property p_count;
        mode_ok && ctrl_q[0] && ctrl_q[1] && count_enable_chain
            |=> clr_on || count_outputs == $past(nxt);
    endproperty
    property p_hold;
        mode_ok && ctrl_q[0] && !(ctrl_q[1] && count_enable_chain)
            |=> clr_on || $stable(count_outputs);
    endproperty
    property p_frozen;
        !hreadyout && !clr_on |=> clr_on || $stable(count_outputs);
    endproperty
    property p_freeze_lag;
        $fell(ce) |-> s_lag;
    endproperty
    property p_okay;
        hresp == `SCNT_HRESP_OKAY;
    endproperty
    property p_rdata_idle;
        hreadyout && !(taken && !hwrite) |=> hrdata == 32'h0;
    endproperty

    a_carry_decode: assert property (p_carry_decode)
        else $error("carry wrong");
    a_async_clear: assert property (p_async_clear)
        else $error("clear missed");
    a_load: assert property (p_load)
        else $error("preset not taken");
    a_count: assert property (p_count)
        else $error("count step wrong");
    a_hold: assert property (p_hold)
        else $error("hold broken");
    a_frozen: assert property (p_frozen)
        else $error("freeze broken");
    a_freeze_lag: assert property (p_freeze_lag)
        else $error("ready lag wrong");
    a_okay: assert property (p_okay)
        else $error("response not okay");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("stray read data");
endmodule // scnt_top_asserts

bind scnt_top scnt_top_asserts #(.MODULUS(MODULUS), .CLEAR_KIND(CLEAR_KIND))
    u_asserts (.clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .async_clear_n(async_clear_n), .count_enable_chain(count_enable_chain),
    .count_outputs(count_outputs), .carry_out(carry_out));

`default_nettype wire

// *** testbench/scnt_up_stage.sv ***
// Upstream binary counter stage that feeds the block's chain enable.
`default_nettype none

module scnt_up_stage (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Own chain enable and a level override.
    input wire logic chain_in,
    input wire logic force_hi,
    // Carry towards the block.
    output logic carry
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] state_q;

    // Counts while enabled, so the block sees one carry in sixteen edges.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= 4'h0;
        end else if (chain_in) begin
            state_q <= state_q + 4'h1;
        end
    end

    // Carry is gated by the chain enable, needing no outside gates.
    assign carry = force_hi || (chain_in && state_q == 4'hF);
endmodule // scnt_up_stage

`default_nettype wire

// *** testbench/tb_scnt_top.sv ***
// Self-checking bench of the decade counter with master clear.
`default_nettype none
`include "scnt_defines.svh"

module tb_scnt_top
    import scnt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Stimulus and wiring
    // ======================================================================
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = `SCNT_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic async_clear_n = 1'h1;
    logic chain_in = 1'h0;
    logic force_hi = 1'h0;
    wire logic hreadyout;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic chain;
    wire logic [3:0] count;
    wire logic carry;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [3:0] prev;

    // Clock, and a ceiling that cuts a hang short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    scnt_top #(.MODULUS(SCNT_MOD_DECADE), .CLEAR_KIND(SCNT_CLR_ASYNC)) u_dut (
        .clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .async_clear_n(async_clear_n),
        .count_enable_chain(chain), .count_outputs(count), .carry_out(carry));
    scnt_up_stage u_up (.clk(clk), .reset(reset), .chain_in(chain_in),
        .force_hi(force_hi), .carry(chain));

    // ======================================================================
    // Shared tasks
    // ======================================================================
    function automatic logic [3:0] dec_next(input logic [3:0] v);
        return v >= 4'h9 ? 4'h0 : v + 4'h1;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One word transfer, entered just after a rising edge.
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    task automatic set_ctrl(input logic [31:0] d);
        ahb(1'h1, `SCNT_CTRL_ADDR, d);
        repeat (2) @(posedge clk);
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic t_regs();
        ahb(1'h0, `SCNT_CTRL_ADDR, 32'h0);
        chk("ctrl reset", rd, `SCNT_CTRL_RESET);
        ahb(1'h1, 32'h0000_0010, 32'hFFFF_FFFF);
        ahb(1'h0, 32'h0000_0010, 32'h0);
        chk("unmapped read", rd, 32'h0);
        ahb(1'h0, `SCNT_CTRL_ADDR, 32'h0);
        chk("ctrl kept", rd, `SCNT_CTRL_RESET);
        ahb(1'h0, `SCNT_STAT_ADDR, 32'h0);
        chk("stat reset", rd, 32'h0000_00C0);
    endtask

    // Preset is taken while the chain enable is high; one low enable holds the state.
    task automatic t_load_hold();
        force_hi <= 1'h1;
        set_ctrl(32'h0000_0070);
        chk("load", count, 4'h7);
        set_ctrl(32'h0000_0001);
        chk("hold par", count, 4'h7);
        force_hi <= 1'h0;
        set_ctrl(32'h0000_0003);
        chk("hold chain", count, 4'h7);
    endtask

    task automatic t_run();
        force_hi <= 1'h1;
        @(posedge clk);
        for (int i = 0; i < 14; i++) begin
            prev = count;
            chk("carry", carry, prev == 4'h9);
            @(posedge clk);
            chk("step", count, dec_next(prev));
        end
        ahb(1'h0, `SCNT_STAT_ADDR, 0);
        chk("wrap", rd[8], 1);
        set_ctrl(32'h0000_0090);
        chk("carry high", carry, 1'h1);
        force_hi <= 1'h0;
        #1;
        chk("carry gated", carry, 1'h0);
        @(posedge clk);
    endtask

    // A decade stage above nine rejoins its sequence.
    task automatic t_illegal();
        set_ctrl(32'h0000_00C0);
        chk("load twelve", count, 4'hC);
        force_hi <= 1'h1;
        ahb(1'h1, `SCNT_CTRL_ADDR, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk("rejoin", count <= 4'h9, 1'h1);
    endtask

    task automatic t_freeze();
        ce <= 1'h0;
        repeat (2) @(posedge clk);
        prev = count;
        repeat (4) @(posedge clk);
        chk("frozen", count, prev);
        chk("ready low", hreadyout, 1'h0);
        ce <= 1'h1;
        repeat (3) @(posedge clk);
    endtask

    // Master clear acts at once; counting resumes after it.
    task automatic t_clear();
        async_clear_n <= 1'h0;
        #1;
        chk("clear now", {carry, count}, 5'h00);
        repeat (3) @(posedge clk);
        chk("clear held", count, 4'h0);
        async_clear_n <= 1'h1;
        repeat (2) @(posedge clk);
        chk("resume", count, 4'h1);
        ahb(1'h0, `SCNT_CTRL_ADDR, 32'h0);
        chk("ctrl after clear", rd, 32'h0000_0003);
    endtask

    // Upstream stage drives the chain: two carries in any 32 edges.
    task automatic t_cascade();
        force_hi <= 1'h0;
        chain_in <= 1'h1;
        @(posedge clk);
        prev = count;
        repeat (32) @(posedge clk);
        chk("cascade", count, dec_next(dec_next(prev)));
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_regs();
        t_load_hold();
        t_run();
        t_illegal();
        t_freeze();
        t_clear();
        t_cascade();
        end_sim();
    end
endmodule // tb_scnt_top

`default_nettype wire
